// >>> design/wbs_pkg.sv
// wbs_pkg: constants for the warning buzzer sequencer
// assumes a 50 MHz core clock; all times in microseconds
package wbs_pkg;
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned PARK_OFF_US    = 610000;
   localparam int unsigned PARK_ON_US     = 75000;
   localparam int unsigned OVSPD_ON_US    = 500000;
   localparam int unsigned OVSPD_OFF_US   = 200000;
   localparam int unsigned STAB_ON_US     = 100000;
   localparam int unsigned STAB_OFF_US    = 100000;
   localparam int unsigned HEAT_ON_US     = 500000;
   localparam int unsigned HEAT_OFF_US    = 500000;
   localparam int unsigned WATER_ON_US    = 500000;
   localparam int unsigned WATER_OFF_US   = 500000;
   localparam int unsigned NUM_REQ        = 5;
   localparam int unsigned REQ_PARK       = 0;
   localparam int unsigned REQ_OVSPD      = 1;
   localparam int unsigned REQ_STAB       = 2;
   localparam int unsigned REQ_HEAT       = 3;
   localparam int unsigned REQ_WATER      = 4;
   localparam int unsigned CNT_W          = 26;
   localparam logic [2:0]  IDX_NONE       = 3'h7;

   typedef enum logic [2:0] {
      WBS_IDLE  = 3'h1,
      WBS_FIRST = 3'h2,
      WBS_SECND = 3'h4
   } wbs_state_type;
endpackage : wbs_pkg

// >>> design/wbs_sequencer.sv
// wbs_sequencer: picks one warning request at a time and plays its cadence
// assumes request inputs are synchronous levels; ignition gates water here
`timescale 1ns/100ps

// Contract
// - Park assist plays 610 ms silent then 75 ms sound, repeating.
// - Overspeed (speed above 120 km/h) plays 500 ms on then 200 ms off.
// - Stability control event plays 100 ms on then 100 ms off.
// - Water-in-fuel with ignition on, and engine overheat, play 500/500 ms.
// - A running pattern is never cut short by a higher request.
// - Pending requests are served in fixed priority, park assist first.
module wbs_sequencer
   import wbs_pkg::*;
#(
   parameter int unsigned PARK_OFF_CYC  = PARK_OFF_US  * CLK_MHZ,
   parameter int unsigned PARK_ON_CYC   = PARK_ON_US   * CLK_MHZ,
   parameter int unsigned OVSPD_ON_CYC  = OVSPD_ON_US  * CLK_MHZ,
   parameter int unsigned OVSPD_OFF_CYC = OVSPD_OFF_US * CLK_MHZ,
   parameter int unsigned STAB_ON_CYC   = STAB_ON_US   * CLK_MHZ,
   parameter int unsigned STAB_OFF_CYC  = STAB_OFF_US  * CLK_MHZ,
   parameter int unsigned HEAT_ON_CYC   = HEAT_ON_US   * CLK_MHZ,
   parameter int unsigned HEAT_OFF_CYC  = HEAT_OFF_US  * CLK_MHZ,
   parameter int unsigned WATER_ON_CYC  = WATER_ON_US  * CLK_MHZ,
   parameter int unsigned WATER_OFF_CYC = WATER_OFF_US * CLK_MHZ
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic       park_assist,
   input  wire logic       overspeed,
   input  wire logic       stability_control,
   input  wire logic       engine_overheat,
   input  wire logic       water_in_fuel,
   input  wire logic       ignition_on,
   output logic            buzzer_q,
   output logic            busy_q,
   output logic [2:0]      active_q
);

   logic [NUM_REQ-1:0] req;
   logic [CNT_W-1:0]   first_len [NUM_REQ];
   logic [CNT_W-1:0]   secnd_len [NUM_REQ];
   logic               first_snd [NUM_REQ];

   wbs_state_type      state_q, state_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   logic [2:0]         active_d;
   logic               buzzer_d;
   logic               busy_d;
   logic [2:0]         pick;

   assign req = {water_in_fuel & ignition_on, engine_overheat,
                 stability_control, overspeed, park_assist};

   assign first_len[REQ_PARK]  = CNT_W'(PARK_OFF_CYC);
   assign secnd_len[REQ_PARK]  = CNT_W'(PARK_ON_CYC);
   assign first_snd[REQ_PARK]  = 1'b0;
   assign first_len[REQ_OVSPD] = CNT_W'(OVSPD_ON_CYC);
   assign secnd_len[REQ_OVSPD] = CNT_W'(OVSPD_OFF_CYC);
   assign first_snd[REQ_OVSPD] = 1'b1;
   assign first_len[REQ_STAB]  = CNT_W'(STAB_ON_CYC);
   assign secnd_len[REQ_STAB]  = CNT_W'(STAB_OFF_CYC);
   assign first_snd[REQ_STAB]  = 1'b1;
   assign first_len[REQ_HEAT]  = CNT_W'(HEAT_ON_CYC);
   assign secnd_len[REQ_HEAT]  = CNT_W'(HEAT_OFF_CYC);
   assign first_snd[REQ_HEAT]  = 1'b1;
   assign first_len[REQ_WATER] = CNT_W'(WATER_ON_CYC);
   assign secnd_len[REQ_WATER] = CNT_W'(WATER_OFF_CYC);
   assign first_snd[REQ_WATER] = 1'b1;

   always_comb begin
      pick = IDX_NONE;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick = 3'(i);
         end
      end
   end

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      active_d = active_q;
      buzzer_d = buzzer_q;
      busy_d   = busy_q;
      case (state_q)
         WBS_IDLE: begin
            buzzer_d = 1'b0;
            busy_d   = 1'b0;
            if (pick != IDX_NONE) begin
               state_d  = WBS_FIRST;
               active_d = pick;
               cnt_d    = first_len[pick] - CNT_W'(1);
               buzzer_d = first_snd[pick];
               busy_d   = 1'b1;
            end
         end
         WBS_FIRST: begin
            if (cnt_q == '0) begin
               state_d  = WBS_SECND;
               cnt_d    = secnd_len[active_q] - CNT_W'(1);
               buzzer_d = ~first_snd[active_q];
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         WBS_SECND: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else if (pick != IDX_NONE) begin
               state_d  = WBS_FIRST;
               active_d = pick;
               cnt_d    = first_len[pick] - CNT_W'(1);
               buzzer_d = first_snd[pick];
            end else begin
               state_d  = WBS_IDLE;
               active_d = IDX_NONE;
               buzzer_d = 1'b0;
               busy_d   = 1'b0;
            end
         end
         default: begin
            state_d  = WBS_IDLE;
            active_d = IDX_NONE;
            buzzer_d = 1'b0;
            busy_d   = 1'b0;
            cnt_d    = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q  <= WBS_IDLE;
         cnt_q    <= '0;
         active_q <= IDX_NONE;
         buzzer_q <= 1'b0;
         busy_q   <= 1'b0;
      end else if (clk_en) begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         active_q <= active_d;
         buzzer_q <= buzzer_d;
         busy_q   <= busy_d;
      end
   end

   // assertions
   a_hold_active: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && !$past(state_q == WBS_SECND)
       && $past(state_q) != WBS_IDLE) |-> $stable(active_q))
      else $error("pattern changed mid period");
   a_no_preempt: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == WBS_FIRST) |=> active_q == $past(active_q))
      else $error("running pattern replaced");
   a_park_silent: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && active_q == 3'(REQ_PARK)) |-> !buzzer_q)
      else $error("park assist sounded in silent phase");
   a_park_sound: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_SECND && active_q == 3'(REQ_PARK)) |-> buzzer_q)
      else $error("park assist silent in sound phase");
   a_ovspd_on: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && active_q == 3'(REQ_OVSPD)) |-> buzzer_q)
      else $error("overspeed not sounding");
   a_ovspd_off: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_SECND && active_q == 3'(REQ_OVSPD)) |-> !buzzer_q)
      else $error("overspeed off phase sounding");
   a_stab_on: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && active_q == 3'(REQ_STAB)) |-> buzzer_q)
      else $error("stability on phase silent");
   a_stab_off: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_SECND && active_q == 3'(REQ_STAB)) |-> !buzzer_q)
      else $error("stability off phase sounding");
   a_heat_sound: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && active_q == 3'(REQ_HEAT)) |-> buzzer_q)
      else $error("overheat on phase silent");
   a_water_sound: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_FIRST && active_q == 3'(REQ_WATER)) |-> buzzer_q)
      else $error("water on phase silent");
   a_water_gate: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == WBS_IDLE && water_in_fuel && !ignition_on
       && req[3:0] == '0) |=> state_q == WBS_IDLE)
      else $error("water warning without ignition");
   a_prio_pick: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == WBS_IDLE && park_assist)
      |=> active_q == 3'(REQ_PARK))
      else $error("priority not honoured");
   a_prio_next: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == WBS_SECND && cnt_q == '0 && park_assist)
      |=> active_q == 3'(REQ_PARK))
      else $error("park assist not served next");
   a_idle_quiet: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == WBS_IDLE) |-> (!buzzer_q && !busy_q))
      else $error("buzzer driven while idle");
   a_freeze_hold: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !clk_en |=> ($stable(state_q) && $stable(cnt_q)
                   && $stable(buzzer_q)))
      else $error("state moved while clock enable low");

   c_park_run: cover property (@(posedge core_clk)
      state_q == WBS_SECND && active_q == 3'(REQ_PARK));
   c_water_run: cover property (@(posedge core_clk)
      state_q == WBS_SECND && active_q == 3'(REQ_WATER));
   c_switch: cover property (@(posedge core_clk)
      clk_en && state_q == WBS_SECND && cnt_q == '0 && pick != active_q
      && pick != IDX_NONE);
   c_freeze: cover property (@(posedge core_clk)
      !clk_en && busy_q);

endmodule // wbs_sequencer

// >>> verif/wbs_buzzer_model.sv
// wbs_buzzer_model: buzzer transducer, measures each sounding burst
// assumes buzzer_q is registered on core_clk, high = sounding
`timescale 1ns/100ps
module wbs_buzzer_model (
   input  wire logic core_clk,
   input  wire logic buzzer_q,
   output int        last_on
);
   int run = 0;
   always @(posedge core_clk) begin
      if (buzzer_q) begin
         run <= run + 1;
      end else if (run != 0) begin
         last_on <= run;
         run     <= 0;
      end
   end
endmodule // wbs_buzzer_model

// >>> verif/warning_buzzer_sequencer_tb_top.sv
// warning_buzzer_sequencer_tb_top: directed bench for wbs_sequencer
// assumes shortened cycle counts; inputs driven on the falling edge
`timescale 1ns/100ps
module warning_buzzer_sequencer_tb_top;
   import wbs_pkg::*;
   // shortened phase lengths in enabled cycles, and the freeze length
   localparam int T_PARK_OFF  = 20;
   localparam int T_PARK_ON   = 5;
   localparam int T_OVSPD_ON  = 10;
   localparam int T_OVSPD_OFF = 4;
   localparam int T_STAB_ON   = 6;
   localparam int T_STAB_OFF  = 6;
   localparam int T_HEAT_ON   = 8;
   localparam int T_HEAT_OFF  = 8;
   localparam int T_WATER_ON  = 8;
   localparam int T_WATER_OFF = 8;
   localparam int T_FREEZE    = 4;
   logic       core_clk, sys_rst, clk_en, ignition_on, buzzer_q, busy_q;
   logic [4:0] req;
   logic [2:0] active_q;
   int         last_on, cycles, n_mismatch, cmp_count;

   wbs_sequencer #(
      .PARK_OFF_CYC      (T_PARK_OFF),
      .PARK_ON_CYC       (T_PARK_ON),
      .OVSPD_ON_CYC      (T_OVSPD_ON),
      .OVSPD_OFF_CYC     (T_OVSPD_OFF),
      .STAB_ON_CYC       (T_STAB_ON),
      .STAB_OFF_CYC      (T_STAB_OFF),
      .HEAT_ON_CYC       (T_HEAT_ON),
      .HEAT_OFF_CYC      (T_HEAT_OFF),
      .WATER_ON_CYC      (T_WATER_ON),
      .WATER_OFF_CYC     (T_WATER_OFF)
   ) dut_u (
      .core_clk          (core_clk),
      .sys_rst           (sys_rst),
      .clk_en            (clk_en),
      .park_assist       (req[0]),
      .overspeed         (req[1]),
      .stability_control (req[2]),
      .engine_overheat   (req[3]),
      .water_in_fuel     (req[4]),
      .ignition_on       (ignition_on),
      .buzzer_q          (buzzer_q),
      .busy_q            (busy_q),
      .active_q          (active_q)
   );
   wbs_buzzer_model model_u (
      .core_clk (core_clk),
      .buzzer_q (buzzer_q),
      .last_on  (last_on)
   );

   task automatic end_of_test();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // one request alone: phase lengths, levels and return to idle
   task automatic play_one(input int i);
      int   fl[5] = '{T_PARK_OFF, T_OVSPD_ON, T_STAB_ON, T_HEAT_ON,
                      T_WATER_ON};
      int   sl[5] = '{T_PARK_ON, T_OVSPD_OFF, T_STAB_OFF, T_HEAT_OFF,
                      T_WATER_OFF};
      logic on1;
      on1 = (i != 0);
      @(negedge core_clk) req[i] = 1'b1;
      step(1);
      chk("active", 32'(i), 32'(active_q));
      chk("busy", 1, 32'(busy_q));
      @(negedge core_clk) req[i] = 1'b0;
      step(fl[i] - 1);
      chk("buzz first", 32'(on1), 32'(buzzer_q));
      step(1);
      chk("buzz second", 32'(!on1), 32'(buzzer_q));
      step(sl[i] - 1);
      chk("busy end", 1, 32'(busy_q));
      step(1);
      chk("idle", 32'(IDX_NONE), 32'(active_q));
      step(1);
      chk("burst", on1 ? fl[i] : sl[i], last_on);
   endtask
   // late higher requests wait, then are served in priority order
   task automatic prio_order();
      @(negedge core_clk) req = 5'h10;
      step(1);
      @(negedge core_clk) req = 5'h03;
      step(15);
      chk("no preempt", 4, 32'(active_q));
      step(1);
      chk("park next", 0, 32'(active_q));
      @(negedge core_clk) req = 5'h02;
      step(25);
      chk("ovspd next", 1, 32'(active_q));
      @(negedge core_clk) req = 5'h00;
      step(14);
      chk("prio idle", 0, 32'(busy_q));
   endtask
   // water in fuel is ignored with ignition off
   task automatic no_ignition();
      @(negedge core_clk) begin
         ignition_on = 1'b0;
         req         = 5'h10;
      end
      step(3);
      chk("gated", 0, 32'(busy_q));
      @(negedge core_clk) begin
         req         = 5'h00;
         ignition_on = 1'b1;
      end
   endtask
   // clock enable low freezes the take and the running phase count
   task automatic freeze();
      @(negedge core_clk) begin
         clk_en = 1'b0;
         req    = 5'h04;
      end
      step(3);
      chk("frozen take", 0, 32'(busy_q));
      @(negedge core_clk) clk_en = 1'b1;
      step(1);
      chk("thaw take", 2, 32'(active_q));
      @(negedge core_clk) begin
         clk_en = 1'b0;
         req    = 5'h00;
      end
      step(T_FREEZE);
      chk("frozen buzz", 1, 32'(buzzer_q));
      @(negedge core_clk) clk_en = 1'b1;
      step(T_STAB_ON - 1);
      chk("thaw first", 1, 32'(buzzer_q));
      step(1);
      chk("thaw second", 0, 32'(buzzer_q));
      step(T_STAB_OFF);
      chk("thaw idle", 0, 32'(busy_q));
      chk("thaw burst", T_STAB_ON + T_FREEZE, last_on);
   endtask
   // reset in mid pattern clears outputs; a held request restarts at once
   task automatic mid_reset();
      @(negedge core_clk) req = 5'h02;
      step(3);
      chk("pre reset", 1, 32'(buzzer_q));
      @(negedge core_clk) sys_rst = 1'b1;
      step(1);
      chk("rst buzz", 0, 32'(buzzer_q));
      chk("rst busy", 0, 32'(busy_q));
      chk("rst active", 32'(IDX_NONE), 32'(active_q));
      @(negedge core_clk) sys_rst = 1'b0;
      step(1);
      chk("restart", 1, 32'(active_q));
      @(negedge core_clk) req = 5'h00;
      step(T_OVSPD_ON + T_OVSPD_OFF);
      chk("rst idle", 0, 32'(busy_q));
      chk("rst burst", T_OVSPD_ON, last_on);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      sys_rst     = 1'b1;
      req         = 5'h00;
      ignition_on = 1'b1;
      clk_en      = 1'b1;
      repeat (10) @(negedge core_clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 5; i++) play_one(i);
      prio_order();
      no_ignition();
      freeze();
      mid_reset();
      end_of_test();
   end
endmodule // warning_buzzer_sequencer_tb_top
